// *** verilog/edge_pkg.sv ***
// package: constants and carriers for the edge set/clear clock circuits
package edge_pkg;

  // ------------------------------------------------------------
  // clock and delay figures
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  // narrowest filter delay known to work, in ns
  localparam int FILTER_DLY_NS = 4;
  // least time rounds up to whole cycles, at least one
  localparam int FILTER_DLY_RAW = (FILTER_DLY_NS * CLK_MHZ + 999) / 1000;
  localparam int FILTER_DLY_CYC = (FILTER_DLY_RAW < 1) ? 1 : FILTER_DLY_RAW;
  // default delays of the feedback paths, in clk cycles
  localparam int DOUBLER_DLY_CYC = 1;
  localparam int MULT_CLR_DLY_CYC = 1;
  localparam int MULT_SET_DLY_CYC = 1;
  localparam int FILTER_RST_DLY_CYC = 1;
  localparam int MULT_STAGES = 4;

  // ------------------------------------------------------------
  // reset levels
  // ------------------------------------------------------------
  localparam logic Q_RESET = 1'b0;
  localparam logic EDGE_PREV_RESET = 1'b1;
  localparam logic SYNC_RESET = 1'b0;

  // outputs of doubler, divider and filter
  typedef struct packed {
    logic doubled;
    logic div_two_thirds;
    logic div_third;
    logic filtered;
  } clk_outs_t;

endpackage

// *** verilog/delay_line.sv ***
// module: shift register standing in for an analog delay element
`timescale 1ns/1ps
module delay_line #(
  parameter int DEPTH = 1,
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic [DEPTH-1:0] sr_q;
  logic [DEPTH-1:0] sr_d;

  // ------------------------------------------------------------
  // shift path
  // ------------------------------------------------------------
  // next value: shift in at bit zero; one stage has no select to make
  generate
    if (DEPTH == 1) begin : g_one
      always_comb begin
        sr_d = din;
      end
    end else begin : g_many
      always_comb begin
        sr_d = {sr_q[DEPTH-2:0], din};
      end
    end
  endgenerate

  // register only
  always_ff @(posedge clk) begin
    if (rst) begin
      sr_q <= {DEPTH{INIT}};
    end else begin
      sr_q <= sr_d;
    end
  end

  assign dout = sr_q[DEPTH-1];
endmodule

// *** verilog/edge_ff.sv ***
// module: d flip-flop whose set and clear act on rising edges only
`timescale 1ns/1ps
module edge_ff (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_evt,
  input wire logic d,
  input wire logic set_lvl,
  input wire logic force_low_edge_input,
  output logic q
);
  import edge_pkg::*;

  logic q_q;
  logic q_d;
  logic set_prev_q;
  logic set_prev_d;
  logic clr_prev_q;
  logic clr_prev_d;
  logic set_rise;
  logic clr_rise;

  // ------------------------------------------------------------
  // edge sensing and state
  // ------------------------------------------------------------
  // a held set or clear level does nothing; only its rise acts
  always_comb begin
    set_rise = set_lvl & ~set_prev_q;
    clr_rise = force_low_edge_input & ~clr_prev_q;
    set_prev_d = set_lvl;
    clr_prev_d = force_low_edge_input;
    q_d = q_q;
    if (clk_evt) begin
      q_d = d;
    end
    // forced edges beat the clock, set beats clear
    if (clr_rise) begin
      q_d = 1'b0;
    end
    if (set_rise) begin
      q_d = 1'b1;
    end
  end

  // previous levels reset high so no edge is seen at release
  always_ff @(posedge clk) begin
    if (rst) begin
      q_q <= Q_RESET;
      set_prev_q <= EDGE_PREV_RESET;
      clr_prev_q <= EDGE_PREV_RESET;
    end else begin
      q_q <= q_d;
      set_prev_q <= set_prev_d;
      clr_prev_q <= clr_prev_d;
    end
  end

  // output only ever changes on a whole clock, never mid-state
  assign q = q_q;
endmodule

// *** verilog/edge_clock_circuits.sv ***
// module: doubler, pulse multiplier, 1/1.5 and 1/3 divider, runt filter
`timescale 1ns/1ps
module edge_clock_circuits #(
  parameter int N_STAGES = edge_pkg::MULT_STAGES,
  parameter int DOUBLER_DLY = edge_pkg::DOUBLER_DLY_CYC,
  parameter int MULT_CLR_DLY = edge_pkg::MULT_CLR_DLY_CYC,
  parameter int MULT_SET_DLY = edge_pkg::MULT_SET_DLY_CYC,
  parameter int FILTER_DLY = edge_pkg::FILTER_DLY_CYC,
  parameter int FILTER_RST_DLY = edge_pkg::FILTER_RST_DLY_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sig_in,
  output edge_pkg::clk_outs_t outs,
  output logic [N_STAGES-1:0] mult_q
);
  import edge_pkg::*;

  // ------------------------------------------------------------
  // input synchroniser
  // ------------------------------------------------------------
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic in_q;
  logic in_d;
  logic in_prev_q;
  logic in_rise;
  logic in_any_edge;

  // accept a change only once stages two and three agree
  always_comb begin
    in_d = in_q;
    if (s2_q == s3_q) begin
      in_d = s3_q;
    end
  end

  // register only
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= SYNC_RESET;
      s2_q <= SYNC_RESET;
      s3_q <= SYNC_RESET;
      in_q <= SYNC_RESET;
      in_prev_q <= SYNC_RESET;
    end else begin
      s1_q <= sig_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      in_q <= in_d;
      in_prev_q <= in_q;
    end
  end

  // edge events of the cleaned input
  assign in_rise = in_q & ~in_prev_q;
  assign in_any_edge = in_q ^ in_prev_q;

  // ------------------------------------------------------------
  // frequency doubler
  // ------------------------------------------------------------
  logic dbl_q;
  logic dbl_clr;

  // own output, delayed, drives the clear edge
  delay_line #(.DEPTH(DOUBLER_DLY), .INIT(Q_RESET)) u_dbl_dly (
    .clk(clk),
    .rst(rst),
    .din(dbl_q),
    .dout(dbl_clr)
  );

  // inverted output fed back to data; both input edges clock it
  edge_ff u_dbl (
    .clk(clk),
    .rst(rst),
    .clk_evt(in_any_edge),
    .d(~dbl_q),
    .set_lvl(1'b0),
    .force_low_edge_input(dbl_clr),
    .q(dbl_q)
  );

  // ------------------------------------------------------------
  // pulse multiplier chain
  // ------------------------------------------------------------
  logic [N_STAGES-1:0] m_q;
  logic [N_STAGES-1:0] m_clr;
  logic [N_STAGES-1:0] m_nq_dly;
  logic [N_STAGES-1:0] m_set;

  // every stage is clocked by the input rise; later ones are also set
  // by the rise of the previous stage's delayed ~q, so stage k adds one
  assign m_set = {m_nq_dly[N_STAGES-2:0], 1'b0};

  genvar g;
  generate
    for (g = 0; g < N_STAGES; g = g + 1) begin : g_stage
      // self clear after its own rise
      delay_line #(.DEPTH(MULT_CLR_DLY), .INIT(Q_RESET)) u_clr_dly (
        .clk(clk),
        .rst(rst),
        .din(m_q[g]),
        .dout(m_clr[g])
      );
      // delayed inverted output toward the next stage
      delay_line #(.DEPTH(MULT_SET_DLY), .INIT(~Q_RESET)) u_set_dly (
        .clk(clk),
        .rst(rst),
        .din(~m_q[g]),
        .dout(m_nq_dly[g])
      );
      edge_ff u_stage (
        .clk(clk),
        .rst(rst),
        .clk_evt(in_rise),
        .d(1'b1),
        .set_lvl(m_set[g]),
        .force_low_edge_input(m_clr[g]),
        .q(m_q[g])
      );
    end
  endgenerate

  assign mult_q = m_q;

  // ------------------------------------------------------------
  // divide by 1.5 and 3
  // ------------------------------------------------------------
  logic div1_q;
  logic div2_q;
  logic div1_prev_q;
  logic div1_fall;

  // flop two is clocked by the fall of flop one (its ~q rise)
  always_ff @(posedge clk) begin
    if (rst) begin
      div1_prev_q <= Q_RESET;
    end else begin
      div1_prev_q <= div1_q;
    end
  end

  assign div1_fall = div1_prev_q & ~div1_q;

  // toggles on each input rise; forced high by flop two's rise
  edge_ff u_div1 (
    .clk(clk),
    .rst(rst),
    .clk_evt(in_rise),
    .d(~div1_q),
    .set_lvl(div2_q),
    .force_low_edge_input(1'b0),
    .q(div1_q)
  );

  // ripple stage of the counter
  edge_ff u_div2 (
    .clk(clk),
    .rst(rst),
    .clk_evt(div1_fall),
    .d(~div2_q),
    .set_lvl(1'b0),
    .force_low_edge_input(1'b0),
    .q(div2_q)
  );

  // ------------------------------------------------------------
  // runt pulse filter
  // ------------------------------------------------------------
  logic flt_clk_lvl;
  logic flt_clk_prev_q;
  logic flt_clk_rise;
  logic flt_q;
  logic flt_rst;

  // clock path: input through the glitch delay
  delay_line #(.DEPTH(FILTER_DLY), .INIT(SYNC_RESET)) u_flt_dly (
    .clk(clk),
    .rst(rst),
    .din(in_q),
    .dout(flt_clk_lvl)
  );

  // rising edge of the delayed copy
  always_ff @(posedge clk) begin
    if (rst) begin
      flt_clk_prev_q <= SYNC_RESET;
    end else begin
      flt_clk_prev_q <= flt_clk_lvl;
    end
  end

  // sample the live input: a glitch already gone reads low
  assign flt_clk_rise = flt_clk_lvl & ~flt_clk_prev_q;

  // reset path: own output delayed back to the clear edge
  delay_line #(.DEPTH(FILTER_RST_DLY), .INIT(Q_RESET)) u_flt_rst (
    .clk(clk),
    .rst(rst),
    .din(flt_q),
    .dout(flt_rst)
  );

  // rests low after reset until a qualifying pulse
  edge_ff u_flt (
    .clk(clk),
    .rst(rst),
    .clk_evt(flt_clk_rise),
    .d(in_q),
    .set_lvl(1'b0),
    .force_low_edge_input(flt_rst),
    .q(flt_q)
  );

  // ------------------------------------------------------------
  // outputs, straight from flops
  // ------------------------------------------------------------
  // late sampling only adds latency, never a partial pulse
  assign outs.doubled = dbl_q;
  assign outs.div_two_thirds = div1_q;
  assign outs.div_third = div2_q;
  assign outs.filtered = flt_q;
endmodule

// *** tb/sig_source.sv ***
// model: upstream source of input pulses in whole clk steps
`timescale 1ns/1ps
module sig_source (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [7:0] width,
  output logic sig
);
  logic [7:0] left_q;
  logic [7:0] left_d;
  // load width on start, then count down while high
  always_comb begin
    left_d = left_q;
    if (start) begin
      left_d = width;
    end else if (left_q != 8'h00) begin
      left_d = left_q - 8'h01;
    end
  end
  // pulse widths live on the clk grid
  always_ff @(posedge clk) begin
    left_q <= rst ? 8'h00 : left_d;
  end
  assign sig = (left_q != 8'h00);
endmodule

// *** tb/edge_properties.sv ***
// checker: port timing of the edge clock circuits
`timescale 1ns/1ps
module edge_properties #(
  parameter int N_STAGES = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sig_in,
  input wire edge_pkg::clk_outs_t outs,
  input wire logic [N_STAGES-1:0] mult_q
);
  import edge_pkg::*;
  logic [7:0] quiet_q;
  logic [7:0] quiet_d;
  logic last_stage;
  assign last_stage = mult_q[N_STAGES-1];
  // cycles since the input was last high
  always_comb begin
    quiet_d = quiet_q;
    if (sig_in) quiet_d = 8'h00;
    else if (quiet_q != 8'hFF) quiet_d = quiet_q + 8'h01;
  end
  always_ff @(posedge clk) begin
    quiet_q <= rst ? 8'h00 : quiet_d;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // widths below assume all feedback delays at one cycle
  reset_clear_a:
    assert property ($fell(rst) |-> outs == '0 && mult_q == '0)
    else $error("outputs not clear after reset");
  dbl_width_a:
    assert property ($rose(outs.doubled) |-> outs.doubled[*2] ##1 !outs.doubled)
    else $error("doubler pulse width wrong");
  mult_width_a:
    assert property ($rose(last_stage) |-> last_stage[*2] ##1 !last_stage)
    else $error("last stage pulse width wrong");
  filt_width_a:
    assert property ($rose(outs.filtered) |-> outs.filtered[*2] ##1 !outs.filtered)
    else $error("filter pulse width wrong");
  dbl_follow_a:
    assert property ($rose(sig_in) ##0 sig_in[*4] |-> ##[0:6] $rose(outs.doubled))
    else $error("doubler missed an input edge");
  filt_pass_a:
    assert property ($rose(sig_in) ##0 sig_in[*6] |-> ##[0:12] $rose(outs.filtered))
    else $error("filter dropped a long pulse");
  // runt width equals the filter delay of four cycles
  filt_runt_a:
    assert property ($rose(sig_in) ##0 sig_in[*4] ##1 !sig_in
      |-> !outs.filtered[*8] ##1 !outs.filtered[*8])
    else $error("filter passed a runt pulse");
  quiet_outs_a:
    assert property (quiet_q >= 8'h14 |-> !$rose(outs.doubled)
      && !$rose(outs.filtered) && !$rose(outs.div_two_thirds))
    else $error("output rose with input idle");
  div_skip_a:
    assert property ($rose(outs.div_third) |-> ##[1:4] outs.div_two_thirds)
    else $error("divider did not skip to three");
  div_wrap_a:
    assert property ($fell(outs.div_third) |-> !outs.div_two_thirds)
    else $error("divider wrapped out of order");
  chain_step_a:
    assert property ($rose(mult_q[1]) && !$rose(mult_q[0])
      |-> $past(mult_q[0], 3) && !mult_q[0])
    else $error("stage two set without stage one falling");
  cover property ($rose(outs.filtered));
  cover property ($rose(outs.div_third));
  cover property ($rose(last_stage));
endmodule

bind edge_clock_circuits edge_properties #(.N_STAGES(N_STAGES)) props (
  .clk(clk), .rst(rst), .sig_in(sig_in), .outs(outs), .mult_q(mult_q));

// *** tb/tb.sv ***
// testbench: pulse counts of the edge clock circuits
`timescale 1ns/1ps
module tb;
  import edge_pkg::*;
  typedef struct packed {
    logic [3:0] dbl;
    logic [3:0] flt;
    logic [3:0] d1r;
    logic [3:0] d2r;
    logic [15:0] mlt;
    logic [1:0] div;
  } note_t;
  logic clk;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic mark = 1'b0;
  logic [7:0] width = 8'h00;
  logic sig_in;
  clk_outs_t outs;
  clk_outs_t prev;
  logic [3:0] mult_q;
  logic [3:0] mprev;
  note_t notes[$];
  note_t seen;
  note_t exp_n;
  int num_errors = 0;
  int check_count = 0;
  int seed = 74222;
  int phase = 0;
  logic [1:0] div_now = 2'b00;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  sig_source src (.clk(clk), .rst(rst), .start(start), .width(width),
    .sig(sig_in));
  // doubler clear delay sets the pulse width the checker expects
  edge_clock_circuits #(.FILTER_DLY(4),
    .DOUBLER_DLY(DOUBLER_DLY_CYC)) DUT (.clk(clk), .rst(rst),
    .sig_in(sig_in), .outs(outs), .mult_q(mult_q));
  // count rises on settled outputs; at each mark compare oldest note
  always @(negedge clk) begin
    if (rst) begin
      seen = '0;
    end else if (mark) begin
      check_count++;
      exp_n = (notes.size() > 0) ? notes.pop_front() : '1;
      if (seen !== exp_n) begin
        num_errors++;
        $display("unexpected counts expected %h seen %h", exp_n, seen);
      end
      seen = '0;
    end else begin
      seen.dbl = seen.dbl + 4'(outs.doubled & ~prev.doubled);
      seen.flt = seen.flt + 4'(outs.filtered & ~prev.filtered);
      seen.d1r = seen.d1r + 4'(outs.div_two_thirds & ~prev.div_two_thirds);
      seen.d2r = seen.d2r + 4'(outs.div_third & ~prev.div_third);
      for (int k = 0; k < 4; k++) begin
        seen.mlt[4*k +: 4] = seen.mlt[4*k +: 4] + 4'(mult_q[k] & ~mprev[k]);
      end
      seen.div = {outs.div_third, outs.div_two_thirds};
    end
    prev = outs;
    mprev = mult_q;
  end
  // one input pulse of w cycles, then a long idle low phase
  task automatic send(input int w);
    note_t n;
    n = '0;
    start <= 1'b1;
    width <= 8'(w);
    @(posedge clk);
    start <= 1'b0;
    if (w >= 3) begin
      n.dbl = 4'h2;
      n.flt = (w > 4) ? 4'h1 : 4'h0;
      n.mlt = 16'h4321;
      n.d1r = (phase == 2) ? 4'h0 : 4'h1;
      n.d2r = (phase == 1) ? 4'h1 : 4'h0;
      div_now = (phase == 0) ? 2'b01 : (phase == 1) ? 2'b11 : 2'b00;
      phase = (phase + 1) % 3;
    end
    n.div = div_now;
    notes.push_back(n);
    repeat (w + 60) @(posedge clk);
    mark <= 1'b1;
    @(posedge clk);
    mark <= 1'b0;
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    phase = 0;
    div_now = 2'b00;
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // glitch, runt, long pulses, reset in mid-run, runt, long pulses
  initial begin
    do_reset();
    send(1);
    send(4);
    for (int k = 0; k < 12; k++) begin
      send(6 + ($unsigned($random(seed)) % 7));
    end
    do_reset();
    send(4);
    for (int k = 0; k < 4; k++) begin
      send(6 + ($unsigned($random(seed)) % 7));
    end
    complete_run();
  end
endmodule
